/* src/acf_pkg.sv */
// Purpose : Shared constants and carriers of the completion flag block
// Assumes : APB word registers, byte address = 4 x register index
// Notes   : Result registers occupy eight consecutive indices
`default_nettype none

package acf_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NPOS   = 8;
  localparam int unsigned RES_W  = 10;
  localparam int unsigned CHAN_W = 4;
  localparam int unsigned IDX_W  = 6;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned SEQ_W  = 9;
  localparam int unsigned IRQ_W  = 2;

  // ==========================================================
  // Register indices
  localparam logic [IDX_W-1:0] IDX_CTRL    = 6'h00;
  localparam logic [IDX_W-1:0] IDX_SEQ     = 6'h05;
  localparam logic [IDX_W-1:0] IDX_IRQ_STS = 6'h06;
  localparam logic [IDX_W-1:0] IDX_IRQ_MSK = 6'h07;
  localparam logic [IDX_W-1:0] IDX_FLAGS   = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_AUTO_COMPARE_ENABLE    = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_CMPOP   = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_RES0    = 6'h10;

  // ==========================================================
  // Field positions and codes
  localparam int unsigned CTRL_FAST_FLAG_CLEAR   = 0;
  localparam int unsigned CTRL_FRZ_LO = 1;
  localparam int unsigned CTRL_FRZ_HI = 2;
  localparam int unsigned CTRL_COMPARE_IRQ_ENABLE = 3;
  localparam int unsigned SEQ_BUSY    = 9;
  localparam int unsigned IRQ_SEQ_END = 0;
  localparam int unsigned IRQ_CMP     = 1;
  localparam logic [1:0]  FRZ_FINISH  = 2'h2;
  localparam logic [1:0]  FRZ_STOP    = 2'h3;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } acf_apb_req_t;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [IDX_W-1:0] idx;
    logic [31:0]      wdata;
  } acf_acc_t;

  // Bits [8:6] last position, [5] continuous, [4] multi, [3:0] channel
  typedef struct packed {
    logic [2:0]        last;
    logic              cont;
    logic              mult;
    logic [CHAN_W-1:0] chan;
  } acf_seq_cfg_t;

  typedef struct packed {
    logic       done;
    logic       last;
    logic [2:0] pos;
  } acf_ev_t;

  function automatic logic acf_mapped(input logic [IDX_W-1:0] idx);
    return (idx == IDX_CTRL) || (idx == IDX_SEQ) || (idx == IDX_IRQ_STS) ||
           (idx == IDX_IRQ_MSK) || (idx == IDX_FLAGS) ||
           (idx == IDX_AUTO_COMPARE_ENABLE) || (idx == IDX_CMPOP) ||
           (idx[5:3] == IDX_RES0[5:3]);
  endfunction : acf_mapped

endpackage : acf_pkg
`default_nettype wire

/* src/acf_apb_slave.sv */
// Purpose : APB slave front end, one access-phase cycle per transfer
// Assumes : Read data is sampled from the register mux at setup
// Notes   : Unmapped or misaligned addresses answer with pslverr
`timescale 1ns/1ps
`default_nettype none

module acf_apb_slave import acf_pkg::*; (
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_n,
  // APB
  input  wire acf_apb_req_t  i_req,
  output logic [31:0]        o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  // Register side
  input  wire logic [31:0]   i_rdata,
  output acf_acc_t           o_acc
);

  logic [31:0] rdata_ff, nxt_rdata;
  logic        err_ff,   nxt_err;
  logic        setup,    access;

  assign setup  = i_req.psel && !i_req.penable;
  assign access = i_req.psel && i_req.penable;

  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_err   = err_ff;
    if (setup) begin
      nxt_rdata = i_rdata;
      nxt_err   = !acf_mapped(i_req.paddr[ADDR_W-1:2]) ||
                  (i_req.paddr[1:0] != 2'h0);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= '0;
      err_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      err_ff   <= nxt_err;
    end
  end

  assign o_prdata    = rdata_ff;
  assign o_pready    = access;
  assign o_pslverr   = access && err_ff;
  assign o_acc.idx   = i_req.paddr[ADDR_W-1:2];
  assign o_acc.wdata = i_req.pwdata;
  assign o_acc.wr    = access && i_req.pwrite && !err_ff;
  assign o_acc.rd    = access && !i_req.pwrite && !err_ff;

endmodule : acf_apb_slave
`default_nettype wire

/* src/acf_seq.sv */
// Purpose : Conversion sequencer stepping through sequence positions
// Assumes : Converter core answers each start with one done pulse
// Notes   : A dropped conversion is issued again at the same position
`timescale 1ns/1ps
`default_nettype none

module acf_seq import acf_pkg::*; (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  // Control
  input  wire logic              i_start,
  input  wire acf_seq_cfg_t      i_cfg,
  input  wire logic              i_abort,
  input  wire logic              i_hold,
  input  wire logic              i_drop,
  // Converter core
  output logic                   o_soc,
  output logic [CHAN_W-1:0]      o_chan,
  input  wire logic              i_eoc,
  // Status
  output logic                   o_active,
  output acf_ev_t                o_ev
);

  typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT} acf_sq_t;

  acf_sq_t           state_ff, nxt_state;
  logic [2:0]        pos_ff,   nxt_pos;
  acf_seq_cfg_t      cfg_ff,   nxt_cfg;
  logic [CHAN_W-1:0] chan_ff,  nxt_chan;

  always_comb begin
    nxt_state = state_ff;
    nxt_pos   = pos_ff;
    nxt_cfg   = cfg_ff;
    o_soc     = 1'b0;
    o_ev      = '0;
    unique case (state_ff)
      SQ_IDLE: ;
      SQ_ISSUE: begin
        if (!i_hold) begin
          o_soc     = 1'b1;
          nxt_state = SQ_WAIT;
        end
      end
      SQ_WAIT: begin
        if (i_eoc) begin
          nxt_state = SQ_ISSUE;
          if (!i_drop) begin
            o_ev.done = 1'b1;
            o_ev.pos  = pos_ff;
            if (pos_ff == cfg_ff.last) begin
              o_ev.last = 1'b1;
              nxt_pos   = '0;
              if (!cfg_ff.cont) begin
                nxt_state = SQ_IDLE;
              end
            end else begin
              nxt_pos = pos_ff + 3'h1;
            end
          end
        end
      end
    endcase
    if (i_abort) begin
      nxt_state = SQ_IDLE;
    end
    if (i_start) begin
      nxt_cfg   = i_cfg;
      nxt_pos   = '0;
      nxt_state = SQ_ISSUE;
    end
    nxt_chan = nxt_cfg.chan + (nxt_cfg.mult ? {1'b0, nxt_pos} : 4'h0);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= SQ_IDLE;
      pos_ff   <= '0;
      cfg_ff   <= '0;
      chan_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      pos_ff   <= nxt_pos;
      cfg_ff   <= nxt_cfg;
      chan_ff  <= nxt_chan;
    end
  end

  assign o_chan   = chan_ff;
  assign o_active = (state_ff != SQ_IDLE);

endmodule : acf_seq
`default_nettype wire

/* src/acf_top.sv */
// Purpose : Converter completion flags, result store and auto compare
// Assumes : Mode inputs and converter core share the bus clock
// Notes   : Registers sit on APB, byte address = 4 x index
// Summary of operation
// R1: Eight flags, one per sequence position
// R2: Flag k set when conversion at position k ends
// R3: With compare on, set only when true
// R4: True compare with irq enable raises interrupt
// R5: Compare positions keep compare value, drop result
// R6: Sequence start write starts and clears flags
// R7: Fast clear off: write one clears flag
// R8: Fast clear on, compare off: read clears
// R9: Fast clear on, compare on: write clears
// R10: Start clear beats set; set beats others
// R11: Stop aborts; leaving stop restarts, clears flags
// R12: Wait mode behaves as run mode
// R13: Freeze continues, finishes, or stops per setting
// R14: Single or continuous, one or many channels
// R15: Reset clears all flags
`timescale 1ns/1ps
`default_nettype none

module acf_top import acf_pkg::*; (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Converter core
  output logic                   o_adc_start,
  output logic [CHAN_W-1:0]      o_adc_chan,
  input  wire logic              i_adc_done,
  input  wire logic [RES_W-1:0]  i_adc_result,
  // System modes
  input  wire logic              i_stop_mode,
  input  wire logic              i_freeze_mode,
  // Interrupt
  output logic                   o_irq
);

  // ==========================================================
  // Bus front end
  acf_apb_req_t req;
  acf_acc_t     acc;
  logic [31:0]  rdata;

  assign req.psel    = i_psel;
  assign req.penable = i_penable;
  assign req.pwrite  = i_pwrite;
  assign req.paddr   = i_paddr;
  assign req.pwdata  = i_pwdata;

  acf_apb_slave u_apb (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_req     (req),
    .o_prdata  (o_prdata),
    .o_pready  (o_pready),
    .o_pslverr (o_pslverr),
    .i_rdata   (rdata),
    .o_acc     (acc)
  );

  // ==========================================================
  // Control registers and mode tracking
  logic [CTRL_W-1:0] ctrl_ff,    nxt_ctrl;
  acf_seq_cfg_t      cfg_ff,     nxt_cfg;
  logic [NPOS-1:0]   auto_compare_enable_ff,    nxt_auto_compare_enable;
  logic [NPOS-1:0]   cmpop_ff,   nxt_cmpop;
  logic [IRQ_W-1:0]  sts_ff,     nxt_sts;
  logic [IRQ_W-1:0]  msk_ff,     nxt_msk;
  logic              stop_d_ff,  nxt_stop_d;
  logic              aborted_ff, nxt_aborted;
  logic [IRQ_W-1:0]  sts_set;
  logic [NPOS-1:0]   cmp_hit_v;
  logic              fast_flag_clear, stop_rise, stop_fall, restart, seq_start;
  logic              active, hold, drop;
  logic [1:0]        frz;
  acf_ev_t           ev;

  assign fast_flag_clear      = ctrl_ff[CTRL_FAST_FLAG_CLEAR];
  assign frz       = ctrl_ff[CTRL_FRZ_HI:CTRL_FRZ_LO];
  assign stop_rise = i_stop_mode && !stop_d_ff;
  assign stop_fall = !i_stop_mode && stop_d_ff;
  // Wait mode has no input: the sequencer runs on unchanged [R12]
  assign restart   = stop_fall && aborted_ff;                   // [R11]
  assign seq_start = (acc.wr && acc.idx == IDX_SEQ) || restart; // [R6] [R11]
  assign hold = i_stop_mode || (i_freeze_mode &&
                (frz == FRZ_FINISH || frz == FRZ_STOP));        // [R13]
  assign drop = i_freeze_mode && (frz == FRZ_STOP);             // [R13]
  assign sts_set[IRQ_SEQ_END] = ev.last;
  assign sts_set[IRQ_CMP]     = |cmp_hit_v && ctrl_ff[CTRL_COMPARE_IRQ_ENABLE]; // [R4]

  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_cfg     = cfg_ff;
    nxt_auto_compare_enable    = auto_compare_enable_ff;
    nxt_cmpop   = cmpop_ff;
    nxt_msk     = msk_ff;
    nxt_sts     = sts_ff;
    nxt_stop_d  = i_stop_mode;
    nxt_aborted = aborted_ff;
    if (acc.wr) begin
      case (acc.idx)
        IDX_CTRL:    nxt_ctrl  = acc.wdata[CTRL_W-1:0];
        IDX_SEQ:     nxt_cfg   = acc.wdata[SEQ_W-1:0];       // [R14]
        IDX_AUTO_COMPARE_ENABLE:    nxt_auto_compare_enable  = acc.wdata[NPOS-1:0];
        IDX_CMPOP:   nxt_cmpop = acc.wdata[NPOS-1:0];
        IDX_IRQ_MSK: nxt_msk   = acc.wdata[IRQ_W-1:0];
        IDX_IRQ_STS: nxt_sts   = sts_ff & ~acc.wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    nxt_sts = nxt_sts | sts_set;
    if (stop_rise && active) begin
      nxt_aborted = 1'b1;                                     // [R11]
    end else if (stop_fall) begin
      nxt_aborted = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_ff    <= '0;
      cfg_ff     <= '0;
      auto_compare_enable_ff    <= '0;
      cmpop_ff   <= '0;
      msk_ff     <= '0;
      sts_ff     <= '0;
      stop_d_ff  <= 1'b0;
      aborted_ff <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      cfg_ff     <= nxt_cfg;
      auto_compare_enable_ff    <= nxt_auto_compare_enable;
      cmpop_ff   <= nxt_cmpop;
      msk_ff     <= nxt_msk;
      sts_ff     <= nxt_sts;
      stop_d_ff  <= nxt_stop_d;
      aborted_ff <= nxt_aborted;
    end
  end

  assign o_irq = |(sts_ff & msk_ff);

  // ==========================================================
  // Sequencer
  acf_seq u_seq (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_start   (seq_start),
    .i_cfg     (nxt_cfg),
    .i_abort   (stop_rise),                                   // [R11]
    .i_hold    (hold),
    .i_drop    (drop),
    .o_soc     (o_adc_start),
    .o_chan    (o_adc_chan),
    .i_eoc     (i_adc_done),
    .o_active  (active),
    .o_ev      (ev)
  );

  // ==========================================================
  // Per-position flags, results and compare
  logic [NPOS-1:0]  flags_ff, nxt_flags, set_v, clr_v;
  logic [RES_W-1:0] res_ff  [NPOS];
  logic [RES_W-1:0] nxt_res [NPOS];

  for (genvar k = 0; k < NPOS; k++) begin : g_pos
    logic sel, at_k, hit;
    assign sel  = (acc.idx[5:3] == IDX_RES0[5:3]) &&
                  (acc.idx[2:0] == 3'(k));
    assign at_k = ev.done && (ev.pos == 3'(k));               // [R1] [R2]
    assign hit  = cmpop_ff[k] ? (i_adc_result >  res_ff[k])
                              : (i_adc_result <= res_ff[k]);
    assign set_v[k] = at_k && (!auto_compare_enable_ff[k] || hit);           // [R3]
    assign cmp_hit_v[k] = at_k && auto_compare_enable_ff[k] && hit;          // [R4]
    assign clr_v[k] =
      (!fast_flag_clear && acc.wr && acc.idx == IDX_FLAGS && acc.wdata[k]) || // [R7]
      (fast_flag_clear && !auto_compare_enable_ff[k] && sel && acc.rd) ||               // [R8]
      (fast_flag_clear && auto_compare_enable_ff[k] && sel && acc.wr);                  // [R9]
    assign nxt_flags[k] = seq_start ? 1'b0 :                  // [R10]
                          set_v[k]  ? 1'b1 :
                          clr_v[k]  ? 1'b0 : flags_ff[k];
    assign nxt_res[k] = (at_k && !auto_compare_enable_ff[k]) ? i_adc_result : // [R5]
                        (acc.wr && sel) ? acc.wdata[RES_W-1:0] : res_ff[k];

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        res_ff[k] <= '0;
      end else begin
        res_ff[k] <= nxt_res[k];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_ff <= '0;                                         // [R15]
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    rdata = '0;
    case (acc.idx)
      IDX_CTRL:    rdata = 32'(ctrl_ff);
      IDX_SEQ:     rdata = 32'({active, cfg_ff});
      IDX_IRQ_STS: rdata = 32'(sts_ff);
      IDX_IRQ_MSK: rdata = 32'(msk_ff);
      IDX_FLAGS:   rdata = 32'(flags_ff);
      IDX_AUTO_COMPARE_ENABLE:    rdata = 32'(auto_compare_enable_ff);
      IDX_CMPOP:   rdata = 32'(cmpop_ff);
      default: begin
        if (acc.idx[5:3] == IDX_RES0[5:3]) begin
          rdata = 32'(res_ff[acc.idx[2:0]]);
        end
      end
    endcase
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_stop_abort;
    i_stop_mode && !stop_d_ff && active && !seq_start;
  endsequence
  sequence s_stop_leave;
    !i_stop_mode && stop_d_ff && aborted_ff;
  endsequence

  seq_clear_a: assert property (seq_start |=> flags_ff == '0) // [R6]
    else $error("flags not cleared by sequence start");
  flag_set_a: assert property (ev.done && !auto_compare_enable_ff[ev.pos] && // [R2]
    !seq_start |=> flags_ff[$past(ev.pos)])
    else $error("flag not set at position end");
  cmp_gate_a: assert property (ev.done && auto_compare_enable_ff[ev.pos] &&  // [R3]
    !cmp_hit_v[ev.pos] && !flags_ff[ev.pos] |=> !flags_ff[$past(ev.pos)])
    else $error("flag set by false compare");
  cmp_irq_a: assert property (|cmp_hit_v && ctrl_ff[CTRL_COMPARE_IRQ_ENABLE] // [R4]
    |=> sts_ff[IRQ_CMP])
    else $error("compare interrupt not raised");
  no_store_a: assert property (ev.done && auto_compare_enable_ff[ev.pos] && !acc.wr // [R5]
    |=> res_ff[$past(ev.pos)] == $past(res_ff[ev.pos]))
    else $error("result stored over compare value");
  w1c_clear_a: assert property (acc.wr && acc.idx == IDX_FLAGS && // [R7]
    !fast_flag_clear && set_v == '0 && !seq_start
    |=> flags_ff == ($past(flags_ff) & ~$past(acc.wdata[NPOS-1:0])))
    else $error("write one did not clear flag");
  rd_clear_a: assert property (acc.rd && fast_flag_clear &&              // [R8]
    acc.idx[5:3] == IDX_RES0[5:3] && !auto_compare_enable_ff[acc.idx[2:0]] &&
    set_v == '0 |=> !flags_ff[$past(acc.idx[2:0])])
    else $error("result read did not clear flag");
  wr_clear_a: assert property (acc.wr && fast_flag_clear &&              // [R9]
    acc.idx[5:3] == IDX_RES0[5:3] && auto_compare_enable_ff[acc.idx[2:0]] &&
    set_v == '0 && !seq_start |=> !flags_ff[$past(acc.idx[2:0])])
    else $error("result write did not clear flag");
  set_wins_a: assert property ((set_v & clr_v) != '0 && !seq_start // [R10]
    |=> (flags_ff & $past(set_v)) == $past(set_v))
    else $error("soft clear beat a set");
  stop_abort_a: assert property (s_stop_abort          // [R11]
    |=> !active && aborted_ff)
    else $error("running sequence not aborted by stop");
  stop_rest_a: assert property (s_stop_leave           // [R11]
    |=> flags_ff == '0 && active)
    else $error("sequence not restarted after stop");
  frz_stop_a: assert property (i_freeze_mode && frz == FRZ_STOP  // [R13]
    |-> !o_adc_start && !ev.done)
    else $error("conversion ran during freeze stop");

endmodule : acf_top
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose : Self-checking bench of the completion flag block
// Assumes : Zero-wait APB, converter core modelled by the bench
// Notes   : Random results and delays from a fixed seed
`timescale 1ns/1ps
`default_nettype none

module tb_top import acf_pkg::*; ();
  // ==========================================================
  // Signals
  logic              i_clk_sys, i_rst_n;
  logic              i_psel, i_penable, i_pwrite;
  logic [ADDR_W-1:0] i_paddr;
  logic [31:0]       i_pwdata, o_prdata;
  logic              o_pready, o_pslverr, o_adc_start, o_irq;
  logic [CHAN_W-1:0] o_adc_chan;
  logic              i_adc_done, i_stop_mode, i_freeze_mode;
  logic [RES_W-1:0]  i_adc_result;
  logic [RES_W-1:0]  res_log [8];
  acf_seq_cfg_t      cur;
  int                n_fail, comparisons, cnt, nst, frc;

  acf_top uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_adc_start(o_adc_start),
    .o_adc_chan(o_adc_chan), .i_adc_done(i_adc_done),
    .i_adc_result(i_adc_result), .i_stop_mode(i_stop_mode),
    .i_freeze_mode(i_freeze_mode), .o_irq(o_irq));

  // ==========================================================
  // Helpers
  function automatic logic [ADDR_W-1:0] ba(input int idx);
    return ADDR_W'(idx * 4);
  endfunction : ba

  function automatic logic [CHAN_W-1:0] exp_chan(acf_seq_cfg_t c, int p);
    return c.mult ? CHAN_W'(int'(c.chan) + p) : c.chan;
  endfunction : exp_chan

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_psel    <= 1'b1;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 64);
    chk(32'(o_pready), 32'h1, "pready");
    r = o_prdata;
    e = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic wr(input int idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ba(idx), d, r, e);
  endtask : wr

  task automatic rd(input int idx, output logic [31:0] r);
    logic e;
    apb(1'b0, ba(idx), 32'h0, r, e);
  endtask : rd

  task automatic cf(input logic [31:0] e);
    logic [31:0] r;
    rd(IDX_FLAGS, r);
    chk(r, e, "flags");
  endtask : cf

  // Interrupt level is looked at once the register update has settled
  task automatic ci(input logic e, input string m);
    @(negedge i_clk_sys);
    chk(32'(o_irq), 32'(e), m);
  endtask : ci

  task automatic wait_cnt(input int k);
    int n;
    n = 0;
    while (cnt < k && n < 3000) begin
      @(posedge i_clk_sys);
      n++;
    end
    chk(32'(cnt >= k), 32'h1, "conversions");
    repeat (3) @(posedge i_clk_sys);
  endtask : wait_cnt

  task automatic run_seq(input acf_seq_cfg_t c, input logic chk_res);
    logic [31:0] r;
    cur = c;
    cnt = 0;
    wr(IDX_SEQ, 32'(c));
    wait_cnt(int'(c.last) + 1);
    cf(32'((1 << (int'(c.last) + 1)) - 1));
    for (int p = 0; p <= int'(c.last) && chk_res; p++) begin
      rd(int'(IDX_RES0) + p, r);
      chk(r, 32'(res_log[p]), "result");
    end
    rd(IDX_SEQ, r);
    chk(32'(r[SEQ_BUSY]), 32'h0, "busy");
  endtask : run_seq

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Clock, watchdog and converter core
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  initial begin
    repeat (30000) @(posedge i_clk_sys);
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end

  initial begin : conv_core
    int d;
    int p;
    forever begin
      @(posedge i_clk_sys);
      if (o_adc_start === 1'b1) begin
        nst++;
        p = cnt % (int'(cur.last) + 1);
        chk(32'(o_adc_chan), 32'(exp_chan(cur, p)), "channel");
        d = $urandom % 4 + 1;
        repeat (d) @(posedge i_clk_sys);
        // Stop mode kills the conversion in flight
        if (i_stop_mode !== 1'b1) begin
          res_log[p] = (frc >= 0) ? RES_W'(frc) : RES_W'($urandom);
          i_adc_done   <= 1'b1;
          i_adc_result <= res_log[p];
          cnt++;
          @(posedge i_clk_sys);
          i_adc_done <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin : main
    acf_seq_cfg_t c;
    logic [31:0]  r;
    logic         e;
    int           k;
    {i_psel, i_penable, i_pwrite, i_adc_done} = 4'h0;
    {i_stop_mode, i_freeze_mode, i_rst_n} = 3'h0;
    i_paddr = '0;
    i_pwdata = '0;
    i_adc_result = '0;
    {n_fail, comparisons, cnt, nst} = '0;
    frc = -1;
    cur = '0;
    void'($urandom(32'he7a5));
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    cf(32'h0);
    apb(1'b0, 8'h3c, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1, "unmapped read");
    apb(1'b1, 8'h29, 32'hff, r, e);
    chk(32'(e), 32'h1, "misaligned");
    $display("test reset done");
    // Full single-channel sequence, then status interrupt
    c = '{last: 3'd7, cont: 1'b0, mult: 1'b0, chan: CHAN_W'($urandom)};
    run_seq(c, 1'b1);
    wr(IDX_IRQ_MSK, 32'h1);
    ci(1'b1, "irq on");
    wr(IDX_IRQ_STS, 32'h1);
    ci(1'b0, "irq cleared");
    wr(IDX_IRQ_MSK, 32'h0);
    // Write-one clear; zero and result read leave flags
    wr(IDX_FLAGS, 32'h0f);
    cf(32'hf0);
    wr(IDX_FLAGS, 32'h0);
    rd(int'(IDX_RES0) + 4, r);
    cf(32'hf0);
    $display("test single sequence done");
    // Random multi-channel sequences, start clears old flags
    for (k = 0; k < 4; k++) begin
      c = '{last: 3'($urandom), cont: 1'b0, mult: 1'b1,
            chan: CHAN_W'($urandom)};
      if (k == 0)
        c.last = 3'd0;
      run_seq(c, 1'b1);
    end
    // Continuous multi-channel run
    c = '{last: 3'd3, cont: 1'b1, mult: 1'b1, chan: 4'hd};
    cur = c;
    cnt = 0;
    wr(IDX_SEQ, 32'(c));
    wait_cnt(10);
    cf(32'h0f);
    c = '{last: 3'd0, cont: 1'b0, mult: 1'b0, chan: 4'h2};
    // Software ends the continuous run before any low power mode
    wr(IDX_SEQ, 32'(c));
    cur = c;
    repeat (30) @(posedge i_clk_sys);
    $display("test multi and continuous done");
    // Auto compare on position 0, greater-than operator
    wr(IDX_CTRL, 32'(1 << CTRL_COMPARE_IRQ_ENABLE));
    wr(IDX_IRQ_MSK, 32'(1 << IRQ_CMP));
    wr(IDX_AUTO_COMPARE_ENABLE, 32'h1);
    wr(IDX_CMPOP, 32'h1);
    wr(IDX_RES0, 32'h200);
    c = '{last: 3'd1, cont: 1'b0, mult: 1'b0, chan: 4'h5};
    frc = 32'h100;
    cur = c;
    cnt = 0;
    wr(IDX_SEQ, 32'(c));
    wait_cnt(2);
    cf(32'h02);
    ci(1'b0, "compare false irq");
    frc = 32'h300;
    cnt = 0;
    wr(IDX_SEQ, 32'(c));
    wait_cnt(2);
    cf(32'h03);
    ci(1'b1, "compare irq");
    rd(IDX_RES0, r);
    chk(r, 32'h200, "compare value kept");
    wr(IDX_CTRL, 32'((1 << CTRL_COMPARE_IRQ_ENABLE) | (1 << CTRL_FAST_FLAG_CLEAR)));
    rd(int'(IDX_RES0) + 1, r);
    chk(r, 32'h300, "result one");
    cf(32'h01);
    wr(IDX_RES0, 32'h200);
    cf(32'h00);
    wr(IDX_IRQ_STS, 32'h3);
    ci(1'b0, "irq after clear");
    wr(IDX_AUTO_COMPARE_ENABLE, 32'h0);
    wr(IDX_CTRL, 32'h0);
    frc = -1;
    $display("test compare done");
    // Stop mode aborts and restarts with flags cleared
    c = '{last: 3'd7, cont: 1'b0, mult: 1'b0, chan: 4'h1};
    cur = c;
    cnt = 0;
    wr(IDX_SEQ, 32'(c));
    wait_cnt(3);
    i_stop_mode <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    k = nst;
    repeat (10) @(posedge i_clk_sys);
    chk(32'(nst), 32'(k), "starts in stop");
    cnt = 0;
    i_stop_mode <= 1'b0;
    cf(32'h0);
    wait_cnt(8);
    cf(32'hff);
    $display("test stop done");
    // Freeze settings: continue, finish, stop
    c = '{last: 3'd0, cont: 1'b0, mult: 1'b0, chan: 4'h7};
    for (int fs = 0; fs < 4; fs++) begin
      wr(IDX_CTRL, 32'(fs << CTRL_FRZ_LO));
      i_freeze_mode <= 1'b1;
      cur = c;
      cnt = 0;
      k = nst;
      wr(IDX_SEQ, 32'(c));
      repeat (20) @(posedge i_clk_sys);
      if (fs < 2)
        chk(32'(cnt), 32'h1, "freeze continue");
      if (2'(fs) >= FRZ_FINISH)
        chk(32'(nst), 32'(k), "freeze stop");
      i_freeze_mode <= 1'b0;
      wait_cnt(1);
      cf(32'h01);
    end
    $display("test freeze done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
